//--- amc_regs.vh
// Operation
// - Clock field 00 runs the internal 64 kHz clock, pin not driven.
// - Clock field 01 runs the internal 64 kHz clock and drives it out.
// - Clock field 10 takes the 64 kHz modulator clock from the pin.
// - Clock field 11 takes the pin clock divided by two.
// - Mode bits three to zero select the filter update rate.
// - Mode code 000 is continuous conversion and the default.
// - Ready indication goes low whenever a new result is stored.
// - Continuous read shifts each new result out on serial clocks, no command.
// - After reset or a register write, first result takes two periods.
// - Later continuous results follow once per update period.
// - Mode code 001 performs exactly one conversion, then stops.
// - Single conversion waits 1 ms start-up, then converts two periods.
// - Single conversion stores result, ready goes low, returns to power-down.
// - Single result stays until next conversion; low ready stays until read or any mode write.
// - Mode code 010 selects idle.
// - Idle holds filter and modulator in reset, clocks still running.
// - Mode code 011 powers everything down, clock output included.
// - Ready bit set on read, before update, on power-down by mode write; cleared on data.
// - Any mode register write resets modulator and filter, sets ready bit.
`ifndef AMC_REGS_VH
`define AMC_REGS_VH

`define AMC_MODE_W 16
`define AMC_DATA_W 24
`define AMC_MODE_RESET 16'h000a
`define AMC_MODE_KEEP 16'he0cf
`define AMC_MD_HI 15
`define AMC_MD_LO 13
`define AMC_CLK_HI 7
`define AMC_CLK_LO 6
`define AMC_FS_HI 3
`define AMC_FS_LO 0

`define AMC_MD_CONT 3'h0
`define AMC_MD_SINGLE 3'h1
`define AMC_MD_IDLE 3'h2
`define AMC_MD_PDOWN 3'h3

`define AMC_CK_INT 2'h0
`define AMC_CK_INT_OUT 2'h1
`define AMC_CK_EXT 2'h2
`define AMC_CK_EXT_DIV2 2'h3

`define AMC_CMD_WEN_BIT 7
`define AMC_CMD_RD_BIT 6
`define AMC_CMD_RS_HI 5
`define AMC_CMD_RS_LO 3
`define AMC_CMD_CREAD_BIT 2
`define AMC_RS_MODE 3'h1
`define AMC_RS_DATA 3'h3
`define AMC_CREAD_EXIT 8'h58

`define AMC_SYS_CLK_KHZ 100000
`define AMC_OSC_KHZ 64
`define AMC_OSC_HALF_CYC (`AMC_SYS_CLK_KHZ / `AMC_OSC_KHZ / 2)
`define AMC_STARTUP_US 1000
`define AMC_STARTUP_CYC ((`AMC_STARTUP_US * (`AMC_SYS_CLK_KHZ / 1000) + 999) / 1000 * 1000)

`endif

//--- amc_pin_sync.v
`timescale 1ns/100ps
// Three-stage synchroniser per bit; output follows once stages two and three agree
module amc_pin_sync #(
   parameter WIDTH = 4,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   // Clocking
   input wire clock,
   input wire rst,
   input wire ce,
   // Pins
   input wire [WIDTH-1:0] pin_in,
   output wire [WIDTH-1:0] pin_out
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg s1_q;
         reg s2_q;
         reg s3_q;
         reg out_q;
         always @(posedge clock) begin
            if (rst) begin
               s1_q <= INIT[i];
               s2_q <= INIT[i];
               s3_q <= INIT[i];
               out_q <= INIT[i];
            end else if (ce) begin
               s1_q <= pin_in[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  out_q <= s3_q;
               end
            end
         end
         assign pin_out[i] = out_q;
      end
   endgenerate
endmodule // amc_pin_sync

//--- amc_ctrl.v
`timescale 1ns/100ps
`include "amc_regs.vh"
module amc_ctrl #(
   parameter [16:0] STARTUP_CYC = `AMC_STARTUP_CYC
) (
   // Clocking
   input wire clock,
   input wire rst,
   input wire ce,
   // Serial port pins
   input wire sclk,
   input wire din,
   input wire cs_n,
   output wire dout_rdy,
   // Clock pin
   input wire clk_pin_i,
   output wire clk_pin_o,
   output wire clk_pin_oe,
   // Filter side
   input wire [`AMC_DATA_W-1:0] sample_data,
   output wire mod_tick,
   output wire mod_filter_rst,
   output wire analog_pwr_en,
   output wire conv_rdy_n,
   output wire [`AMC_MODE_W-1:0] mode_reg
);
   localparam [2:0] ST_OFF = 3'h0;
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_WARM = 3'h2;
   localparam [2:0] ST_CONV = 3'h3;
   localparam [2:0] ST_RUN = 3'h4;
   localparam [1:0] SP_CMD = 2'h0;
   localparam [1:0] SP_WR = 2'h1;
   localparam [1:0] SP_RD = 2'h2;

   // Modulator ticks per output word for each rate code
   function [11:0] rate_ticks;
      input [3:0] fs;
      begin
         case (fs)
            4'h1: rate_ticks = 12'd136;
            4'h2: rate_ticks = 12'd264;
            4'h3: rate_ticks = 12'd520;
            4'h4: rate_ticks = 12'd1032;
            4'h5: rate_ticks = 12'd1280;
            4'h6: rate_ticks = 12'd1641;
            4'h7: rate_ticks = 12'd1928;
            4'h8: rate_ticks = 12'd3265;
            default: rate_ticks = 12'd1280;
         endcase
      end
   endfunction

   // Synchronised pins
   wire [3:0] pin_s;
   amc_pin_sync #(
      .WIDTH(4),
      .INIT(4'b0101)
   ) u_sync (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .pin_in({clk_pin_i, cs_n, din, sclk}),
      .pin_out(pin_s)
   );
   wire sclk_s = pin_s[0];
   wire din_s = pin_s[1];
   wire cs_n_s = pin_s[2];
   wire ext_s = pin_s[3];

   reg [`AMC_MODE_W-1:0] mode_q;
   reg [2:0] st_q;
   reg [`AMC_DATA_W-1:0] data_q;
   reg rdy_q;
   reg sclk_p_q;
   reg ext_p_q;
   reg div_q;
   reg osc_q;
   reg [10:0] osc_cnt_q;
   reg [11:0] tk_cnt_q;
   reg first_q;
   reg [16:0] warm_q;
   reg [1:0] sp_q;
   reg [4:0] bit_q;
   reg [4:0] len_q;
   reg [2:0] rs_q;
   reg [15:0] sh_in_q;
   reg [`AMC_DATA_W-1:0] sh_out_q;
   reg dout_q;
   reg cread_q;
   reg rd_data_q;
   reg tick_q;

   wire [2:0] md = mode_q[`AMC_MD_HI:`AMC_MD_LO];
   wire [1:0] cks = mode_q[`AMC_CLK_HI:`AMC_CLK_LO];
   wire powered = (st_q != ST_OFF);
   wire sclk_rise = sclk_s & ~sclk_p_q;
   wire sclk_fall = ~sclk_s & sclk_p_q;
   wire ext_rise = ext_s & ~ext_p_q;
   wire [7:0] cmd_byte = {sh_in_q[6:0], din_s};
   wire [15:0] wr_word = {sh_in_q[14:0], din_s};

   // Mode register write, reserved bits forced to zero
   wire mode_wr = ce && !cs_n_s && sclk_rise && sp_q == SP_WR && bit_q == 5'd15;
   wire [`AMC_MODE_W-1:0] mode_new = wr_word & `AMC_MODE_KEEP;

   wire osc_wrap = (osc_cnt_q == `AMC_OSC_HALF_CYC - 1);
   wire osc_tick = osc_wrap & ~osc_q;
   wire ext_tick = ext_rise & (cks == `AMC_CK_EXT);
   wire div_tick = ext_rise & div_q & (cks == `AMC_CK_EXT_DIV2);
   wire tick = cks[1] ? (ext_tick | div_tick) : osc_tick;

   wire [11:0] period = rate_ticks(mode_q[`AMC_FS_HI:`AMC_FS_LO]);
   wire converting = (st_q == ST_CONV) || (st_q == ST_RUN);
   wire period_end = tick && tk_cnt_q == period - 12'd1;
   wire pre_end = tick && tk_cnt_q == period - 12'd2;
   wire result_due = first_q;
   wire new_result = converting && period_end && result_due;

   always @(posedge clock) begin
      if (rst) begin
         osc_cnt_q <= 11'h000;
         osc_q <= 1'b0;
         sclk_p_q <= 1'b1;
         ext_p_q <= 1'b0;
         div_q <= 1'b0;
         tick_q <= 1'b0;
      end else if (ce) begin
         sclk_p_q <= sclk_s;
         ext_p_q <= ext_s;
         tick_q <= tick & converting;
         if (!powered || cks[1]) begin
            osc_cnt_q <= 11'h000;
            osc_q <= 1'b0;
         end else if (osc_wrap) begin
            osc_cnt_q <= 11'h000;
            osc_q <= ~osc_q;
         end else begin
            osc_cnt_q <= osc_cnt_q + 11'h001;
         end
         if (ext_rise) begin
            div_q <= ~div_q;
         end
      end
   end

   // Operating sequence
   always @(posedge clock) begin
      if (rst) begin
         mode_q <= `AMC_MODE_RESET;
         st_q <= ST_RUN;
         tk_cnt_q <= 12'h000;
         first_q <= 1'b0;
         warm_q <= 17'h00000;
         data_q <= {`AMC_DATA_W{1'b0}};
         rdy_q <= 1'b1;
      end else if (ce) begin
         if (mode_wr) begin
            mode_q <= mode_new;
            tk_cnt_q <= 12'h000;
            first_q <= 1'b0;
            warm_q <= 17'h00000;
            // write resets filter, sets ready bit
            rdy_q <= 1'b1;
            // new rate or clock restarts conversion
            case (mode_new[`AMC_MD_HI:`AMC_MD_LO])
               `AMC_MD_CONT: st_q <= ST_RUN;
               `AMC_MD_SINGLE: st_q <= ST_WARM;
               `AMC_MD_IDLE: st_q <= ST_IDLE;
               `AMC_MD_PDOWN: st_q <= ST_OFF;
               default: st_q <= ST_IDLE;
            endcase
         end else begin
            case (st_q)
               ST_WARM: begin
                  if (warm_q == STARTUP_CYC - 17'd1) begin
                     st_q <= ST_CONV;
                  end else begin
                     warm_q <= warm_q + 17'd1;
                  end
               end
               ST_CONV, ST_RUN: begin
                  if (period_end) begin
                     tk_cnt_q <= 12'h000;
                     first_q <= 1'b1;
                  end else if (tick) begin
                     tk_cnt_q <= tk_cnt_q + 12'h001;
                  end
                  if (new_result) begin
                     data_q <= sample_data;
                     rdy_q <= 1'b0;
                     // single conversion stops here, back to power-down
                     if (st_q == ST_CONV) begin
                        st_q <= ST_OFF;
                        mode_q[`AMC_MD_HI:`AMC_MD_LO] <= `AMC_MD_PDOWN;
                     end
                  end else if ((pre_end && result_due) || rd_data_q) begin
                     // set before update or after read
                     rdy_q <= 1'b1;
                  end
               end
               default: begin
                  tk_cnt_q <= 12'h000;
                  first_q <= 1'b0;
                  if (rd_data_q) begin
                     rdy_q <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // Serial port
   always @(posedge clock) begin
      if (rst) begin
         sp_q <= SP_CMD;
         bit_q <= 5'h00;
         len_q <= 5'h00;
         rs_q <= 3'h0;
         sh_in_q <= 16'h0000;
         sh_out_q <= {`AMC_DATA_W{1'b0}};
         dout_q <= 1'b1;
         cread_q <= 1'b0;
         rd_data_q <= 1'b0;
      end else if (ce) begin
         rd_data_q <= 1'b0;
         if (cs_n_s) begin
            sp_q <= SP_CMD;
            bit_q <= 5'h00;
            dout_q <= rdy_q;
         end else if (sp_q == SP_RD) begin
            // First fall repeats the MSB, so the host sees it at the first rise
            if (sclk_fall) begin
               dout_q <= sh_out_q[`AMC_DATA_W-1];
               sh_out_q <= {sh_out_q[`AMC_DATA_W-2:0], 1'b0};
            end
            if (sclk_rise) begin
               if (bit_q == len_q - 5'd1) begin
                  sp_q <= SP_CMD;
                  bit_q <= 5'h00;
                  rd_data_q <= (rs_q == `AMC_RS_DATA);
               end else begin
                  bit_q <= bit_q + 5'd1;
               end
            end
         end else if (sp_q == SP_WR) begin
            if (sclk_rise) begin
               sh_in_q <= wr_word;
               if (bit_q == 5'd15) begin
                  sp_q <= SP_CMD;
                  bit_q <= 5'h00;
               end else begin
                  bit_q <= bit_q + 5'd1;
               end
            end
         end else if (cread_q && new_result && bit_q == 5'h00) begin
            // result pushed out without a command
            sp_q <= SP_RD;
            rs_q <= `AMC_RS_DATA;
            len_q <= 5'd24;
            dout_q <= sample_data[`AMC_DATA_W-1];
            sh_out_q <= sample_data;
         end else if (sclk_rise) begin
            sh_in_q <= {8'h00, cmd_byte};
            bit_q <= bit_q + 5'd1;
            if (bit_q == 5'd7) begin
               bit_q <= 5'h00;
               rs_q <= cmd_byte[`AMC_CMD_RS_HI:`AMC_CMD_RS_LO];
               if (cread_q) begin
                  if (cmd_byte == `AMC_CREAD_EXIT) begin
                     cread_q <= 1'b0;
                  end
               end else if (!cmd_byte[`AMC_CMD_WEN_BIT]) begin
                  if (!cmd_byte[`AMC_CMD_RD_BIT]) begin
                     if (cmd_byte[`AMC_CMD_RS_HI:`AMC_CMD_RS_LO] == `AMC_RS_MODE) begin
                        sp_q <= SP_WR;
                     end
                  end else if (cmd_byte[`AMC_CMD_RS_HI:`AMC_CMD_RS_LO] == `AMC_RS_DATA
                               && cmd_byte[`AMC_CMD_CREAD_BIT]) begin
                     cread_q <= 1'b1;
                  end else if (cmd_byte[`AMC_CMD_RS_HI:`AMC_CMD_RS_LO] == `AMC_RS_DATA) begin
                     sp_q <= SP_RD;
                     len_q <= 5'd24;
                     dout_q <= data_q[`AMC_DATA_W-1];
                     sh_out_q <= data_q;
                  end else if (cmd_byte[`AMC_CMD_RS_HI:`AMC_CMD_RS_LO] == `AMC_RS_MODE) begin
                     sp_q <= SP_RD;
                     len_q <= 5'd16;
                     dout_q <= mode_q[`AMC_MODE_W-1];
                     sh_out_q <= {mode_q, 8'h00};
                  end else begin
                     sp_q <= SP_RD;
                     len_q <= 5'd8;
                     dout_q <= 1'b0;
                     sh_out_q <= {`AMC_DATA_W{1'b0}};
                  end
               end
            end
         end else if (bit_q == 5'h00) begin
            dout_q <= rdy_q;
         end
      end
   end

   assign dout_rdy = dout_q;
   // clock pin driven only when selected
   assign clk_pin_oe = powered && cks == `AMC_CK_INT_OUT;
   assign clk_pin_o = osc_q;
   assign mod_tick = tick_q;
   // filter held in reset outside conversion
   assign mod_filter_rst = !converting;
   assign analog_pwr_en = powered;
   assign conv_rdy_n = rdy_q;
   assign mode_reg = mode_q;
endmodule // amc_ctrl

//--- amc_ctrl_asserts.sv
`timescale 1ns/100ps
`include "amc_regs.vh"
module amc_ctrl_asserts (
   // Clocking
   input wire clock,
   input wire rst,
   // Clock pin
   input wire clk_pin_i,
   input wire clk_pin_oe,
   // Filter side
   input wire mod_tick,
   input wire mod_filter_rst,
   input wire analog_pwr_en,
   input wire conv_rdy_n,
   input wire [`AMC_MODE_W-1:0] mode_reg
);
   wire [2:0] md = mode_reg[`AMC_MD_HI:`AMC_MD_LO];
   wire [1:0] ck = mode_reg[`AMC_CLK_HI:`AMC_CLK_LO];
   reg pin_q;
   reg vld_q;
   reg [1:0] rise_q;
   reg [11:0] gap_q;
   reg [15:0] mode_q;
   wire [1:0] rises = rise_q + {1'b0, clk_pin_i & ~pin_q};
   // Pin edges and cycles since the last tick, valid once a tick was seen in this mode
   always @(posedge clock) begin
      pin_q <= clk_pin_i;
      mode_q <= mode_reg;
      rise_q <= mod_tick ? 2'h0 : rises;
      gap_q <= mod_tick ? 12'h001 : gap_q + 12'h001;
      vld_q <= !rst && mode_reg == mode_q && (vld_q || mod_tick);
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_pin_drive;
      clk_pin_oe == (ck == `AMC_CK_INT_OUT && md != `AMC_MD_PDOWN);
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("clock pin enable wrong");
   property p_pdown;
      (md == `AMC_MD_PDOWN) [*2] |-> !analog_pwr_en && mod_filter_rst;
   endproperty
   a_pdown: assert property (p_pdown) else $error("power down not applied");
   property p_idle;
      (md == `AMC_MD_IDLE) [*2] |-> mod_filter_rst && !mod_tick && analog_pwr_en;
   endproperty
   a_idle: assert property (p_idle) else $error("idle not holding filter");
   property p_single_end;
      md == `AMC_MD_SINGLE ##1 md == `AMC_MD_PDOWN && mod_tick |-> ##[0:2] !conv_rdy_n;
   endproperty
   a_single_end: assert property (p_single_end) else $error("single end without ready");
   property p_write_rdy;
      $changed(mode_reg) && md != `AMC_MD_PDOWN |-> ##[0:1] conv_rdy_n;
   endproperty
   a_write_rdy: assert property (p_write_rdy) else $error("mode write kept ready low");
   property p_rdy_conv;
      $fell(conv_rdy_n) |-> !$past(mod_filter_rst);
   endproperty
   a_rdy_conv: assert property (p_rdy_conv) else $error("ready fell outside conversion");
   property p_ext_rate;
      mod_tick && vld_q && ck == `AMC_CK_EXT |-> rises == 2'h1;
   endproperty
   a_ext_rate: assert property (p_ext_rate) else $error("external tick rate wrong");
   property p_div2_rate;
      mod_tick && vld_q && ck == `AMC_CK_EXT_DIV2 |-> rises == 2'h2;
   endproperty
   a_div2_rate: assert property (p_div2_rate) else $error("halved tick rate wrong");
   property p_int_rate;
      mod_tick && vld_q && !ck[1] |-> gap_q == 2 * `AMC_OSC_HALF_CYC;
   endproperty
   a_int_rate: assert property (p_int_rate) else $error("internal tick rate wrong");
   c_result: cover property ($fell(conv_rdy_n));
   c_single: cover property (md == `AMC_MD_SINGLE ##1 md == `AMC_MD_PDOWN);
   c_div2: cover property (mod_tick && vld_q && ck == `AMC_CK_EXT_DIV2);
endmodule // amc_ctrl_asserts

//--- amc_host_model.sv
`timescale 1ns/100ps
module amc_host_model (
   // Clocking
   input wire clock,
   // Serial port
   output reg sclk,
   output reg din,
   output reg cs_n,
   input wire dout_rdy
);
   initial begin
      sclk = 1'b1;
      din = 1'b1;
      cs_n = 1'b1;
   end
   // Eight cycles low, eight high; input bit taken just before each rise
   task shift(input int n, input logic [23:0] w, output logic [23:0] r);
      int i;
      begin
         r = 24'h0;
         for (i = n - 1; i >= 0; i--) begin
            @(posedge clock);
            sclk <= 1'b0;
            din <= w[i];
            cs_n <= 1'b0;
            repeat (7) @(posedge clock);
            @(negedge clock);
            r[i] = dout_rdy;
            @(posedge clock);
            sclk <= 1'b1;
            repeat (7) @(posedge clock);
         end
         din <= ~din;
      end
   endtask
   task wr_mode(input logic [15:0] w);
      logic [23:0] r;
      begin
         shift(8, 24'h000008, r);
         shift(16, {8'h00, w & 16'hffcf}, r);
      end
   endtask
   task rd(input logic [7:0] c, input int n, output logic [23:0] r);
      begin
         shift(8, {16'h0000, c}, r);
         shift(n, 24'h000000, r);
      end
   endtask
endmodule // amc_host_model

//--- adc_mode_and_clock_control_tb.sv
`timescale 1ns/100ps
`include "amc_regs.vh"
module adc_mode_and_clock_control_tb;
   typedef struct {logic [15:0] w; logic oe; logic pw; logic fr; int sp;} amc_row_t;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic ext_q = 1'b0;
   logic [2:0] ediv_q = 3'h0;
   logic [23:0] smp = 24'h5a3c96;
   logic [23:0] r;
   wire sclk, din, cs_n, dout_rdy, clk_pin_o, clk_pin_oe, mod_tick, mod_filter_rst;
   wire analog_pwr_en, conv_rdy_n;
   wire [15:0] mode_reg;
   wire clk_pin = clk_pin_oe ? clk_pin_o : ext_q;
   int n_mismatch = 0;
   int tests_run = 0;
   int tick_n = 0;
   int t0, i, sp;
   amc_row_t rows [6] = '{'{16'h0001, 1'b0, 1'b1, 1'b0, 2 * `AMC_OSC_HALF_CYC},
      '{16'h0041, 1'b1, 1'b1, 1'b0, 2 * `AMC_OSC_HALF_CYC}, '{16'h4041, 1'b1, 1'b1, 1'b1, 0},
      '{16'h6041, 1'b0, 1'b0, 1'b1, 0}, '{16'h0081, 1'b0, 1'b1, 1'b0, 16},
      '{16'h00c1, 1'b0, 1'b1, 1'b0, 32}};
   always #5 clock = ~clock;
   // external clock, scaled to 16 cycles
   always @(posedge clock) begin
      ediv_q <= ediv_q + 3'h1;
      if (ediv_q == 3'h7) ext_q <= ~ext_q;
      if (mod_tick === 1'b1) tick_n <= tick_n + 1;
   end
   amc_ctrl #(.STARTUP_CYC(17'd50)) DUT (.clock(clock), .rst(rst), .ce(ce), .sclk(sclk),
      .din(din), .cs_n(cs_n), .dout_rdy(dout_rdy), .clk_pin_i(clk_pin), .clk_pin_o(clk_pin_o),
      .clk_pin_oe(clk_pin_oe), .sample_data(smp), .mod_tick(mod_tick),
      .mod_filter_rst(mod_filter_rst), .analog_pwr_en(analog_pwr_en),
      .conv_rdy_n(conv_rdy_n), .mode_reg(mode_reg));
   amc_host_model host (.clock(clock), .sclk(sclk), .din(din), .cs_n(cs_n), .dout_rdy(dout_rdy));
   task chk(input logic [23:0] g, input logic [23:0] e);
      begin
         tests_run++;
         if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task chk_rng(input int g, input int lo, input int hi);
      begin
         tests_run++;
         if (g < lo || g > hi) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
         end
      end
   endtask
   task wait_rdy(input int lim);
      int k;
      begin
         @(negedge clock);
         for (k = 0; k < lim && conv_rdy_n !== 1'b0; k++) @(negedge clock);
      end
   endtask
   // Cycles between two ticks, zero if none comes
   task meas(output int s);
      int k;
      begin
         s = 0;
         @(negedge clock);
         for (k = 0; k < 4000 && mod_tick !== 1'b1; k++) @(negedge clock);
         if (k < 4000) begin
            @(negedge clock);
            for (s = 1; s < 4000 && mod_tick !== 1'b1; s++) @(negedge clock);
         end
      end
   endtask
   task tend(input string s);
      $display("test %s done", s);
   endtask
   task final_report;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
         if (n_mismatch == 0 && tests_run > 0) begin
            $display("No errors found");
         end else begin
            $display("Errors were found");
         end
         $finish;
      end
   endtask
   initial begin
      #900000;
      n_mismatch++;
      final_report;
   end
   initial begin
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      chk(mode_reg, 16'h000a);
      chk(conv_rdy_n, 1'b1);
      chk(clk_pin_oe, 1'b0);
      chk(mod_filter_rst, 1'b0);
      tend("reset");
      for (i = 0; i < 6; i++) begin
         host.wr_mode(rows[i].w);
         host.rd(8'h48, 16, r);
         @(negedge clock);
         chk(r[15:0], rows[i].w & `AMC_MODE_KEEP);
         chk(clk_pin_oe, rows[i].oe);
         chk(analog_pwr_en, rows[i].pw);
         chk(mod_filter_rst, rows[i].fr);
         meas(sp);
         chk_rng(sp, rows[i].sp, rows[i].sp);
      end
      tend("rows");
      host.wr_mode(16'h0081);
      t0 = tick_n;
      wait_rdy(8000);
      chk_rng(tick_n - t0, 271, 273);
      t0 = tick_n;
      host.rd(8'h58, 24, r);
      chk(r, smp);
      @(negedge clock);
      chk(conv_rdy_n, 1'b1);
      wait_rdy(4000);
      chk_rng(tick_n - t0, 135, 137);
      tend("continuous");
      host.wr_mode(16'h0082);
      t0 = tick_n;
      @(negedge clock);
      chk(conv_rdy_n, 1'b1);
      wait_rdy(12000);
      chk_rng(tick_n - t0, 527, 529);
      tend("restart");
      host.wr_mode(16'h2081);
      smp <= 24'hc3a51e;
      t0 = tick_n;
      for (i = 0; mod_tick !== 1'b1 && i < 500; i++) @(negedge clock);
      chk_rng(i, 40, 100);
      wait_rdy(8000);
      chk_rng(tick_n - t0, 271, 273);
      @(negedge clock);
      chk(mode_reg[15:13], `AMC_MD_PDOWN);
      chk(analog_pwr_en, 1'b0);
      t0 = tick_n;
      repeat (3000) @(negedge clock);
      chk(conv_rdy_n, 1'b0);
      chk_rng(tick_n - t0, 0, 0);
      host.rd(8'h58, 24, r);
      chk(r, 24'hc3a51e);
      @(negedge clock);
      chk(conv_rdy_n, 1'b1);
      tend("single");
      // Frozen clock enable: a whole mode write must be ignored
      @(posedge clock);
      ce <= 1'b0;
      host.wr_mode(16'h0081);
      @(negedge clock);
      chk(mode_reg, 16'h6081);
      @(posedge clock);
      ce <= 1'b1;
      repeat (8) @(negedge clock);
      chk(mode_reg, 16'h6081);
      chk(analog_pwr_en, 1'b0);
      chk(conv_rdy_n, 1'b1);
      tend("freeze");
      host.wr_mode(16'h0081);
      host.shift(8, 24'h00005c, r);
      for (i = 0; i < 2; i++) begin
         smp <= (i == 0) ? 24'h13579b : 24'h2468ac;
         wait_rdy(8000);
         host.shift(24, 24'h000000, r);
         chk(r, (i == 0) ? 24'h13579b : 24'h2468ac);
      end
      host.shift(8, {16'h0000, `AMC_CREAD_EXIT}, r);
      host.rd(8'h48, 16, r);
      chk(r[15:0], 16'h0081);
      tend("cread");
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      chk(mode_reg, 16'h000a);
      chk(conv_rdy_n, 1'b1);
      chk(dout_rdy, 1'b1);
      chk(analog_pwr_en, 1'b1);
      chk(mod_filter_rst, 1'b0);
      tend("reset again");
      final_report;
   end
endmodule // adc_mode_and_clock_control_tb
bind amc_ctrl amc_ctrl_asserts u_chk (.clock(clock), .rst(rst), .clk_pin_i(clk_pin_i),
   .clk_pin_oe(clk_pin_oe), .mod_tick(mod_tick), .mod_filter_rst(mod_filter_rst),
   .analog_pwr_en(analog_pwr_en), .conv_rdy_n(conv_rdy_n), .mode_reg(mode_reg));
